// [verilog/dcs_exec.sv]
/*
 Execution datapath: binary-to-decimal convert finish, fullword and
 halfword store, address-store-compare, spec and protection handling.
 Assumes a microprogram sequencer drives start pulses and operands,
 and main storage takes doubleword writes with byte marks.
*/
//
// Contract
// - count bits; branch at seven, next byte
// - loop bytes until serial counter three
// - negative: final add, minus sign code
// - shift left four, all marks, store
// - positive: plus sign, shift, store
// - excess-six gating only for convert
// - sum to both registers, double
// - add six when half-byte five plus
// - all half-bytes 28-63 in parallel
// - fullword: bit 61 picks word marks
// - halfword stores low sixteen bits only
// - misaligned halfword raises spec, suppressed
// - address 21-23 loads serial counter
// - adder counter all ones minus one
// - mark n gates bits 8n..8n+7
// - high byte, request, counters step
// - two's complement compare sets refetch
// - refetch trigger sampled at next fetch
// - low byte from source register, end-op
// - protection check: no store, late interrupt
// - positive sign code is 1100
// - sign bit copied into sign flag
`timescale 1ns/1ps
`default_nettype none
`include "dcs_defs.svh"
module dcs_exec (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic start_in,
    input wire dcs_pkg::op_e op_in,
    input wire logic [63:0] operand_in,
    input wire logic [23:0] addr_in,
    input wire logic [23:0] next_instr_counter_in,
    input wire logic minus_alt_in,
    input wire logic prot_check_in,
    input wire logic ifetch_in,
    output logic busy_out,
    output logic end_op_out,
    output logic spec_int_out,
    output logic prot_int_out,
    output logic refetch_out,
    output logic mem_write_out,
    output logic [63:0] mem_data_out,
    output logic [7:0] mem_marks_out,
    output logic [63:0] result_out
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_CONV = 7'b0000010,
        S_TERM = 7'b0000100,
        S_SIGN = 7'b0001000,
        S_HIGH = 7'b0010000,
        S_LOW = 7'b0100000,
        S_WAIT = 7'b1000000
    } state_e;
    state_e state;
    dcs_pkg::op_e op;
    logic [2:0] adder_byte_counter;
    logic [2:0] serial_byte_counter;
    logic [7:0] serial_sum_latch;
    logic [63:0] source;
    logic [67:0] wide_work_register;
    logic [63:0] shift_pair_register;
    logic [63:0] outbound_doubleword_register;
    logic [7:0] marks;
    logic sign_flag;
    logic refetch_trigger;
    logic late_prot;
    logic prot_armed;
    logic issue;
    logic [2:0] wait_count;
    logic [63:0] parallel_input_a;
    logic [63:0] parallel_input_b;
    logic [63:0] parallel_sum_latch;
    logic [23:0] asc_sum;
    logic asc_hit;
    dcs_pkg::store_req_s req;
    dcs_pkg::store_req_s req_done;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic needs_six(input logic [3:0] d);
        needs_six = d[3] | (d[2] & d[1]) | (d[2] & d[0]);
    endfunction : needs_six
    function automatic logic [63:0] byte_place(input logic [7:0] b, input logic [2:0] pos);
        byte_place = {56'h0, b} << ({3'h7 - pos, 3'h0});
    endfunction : byte_place
    function automatic logic [7:0] mark_of(input logic [2:0] pos);
        mark_of = 8'h80 >> pos;
    endfunction : mark_of

    // ----------------------------------------
    // Parallel adder
    // ----------------------------------------
    always_comb begin
        parallel_input_a = {shift_pair_register[62:0], 1'b0};
        parallel_input_b = 64'h0;
        if (op == dcs_pkg::OP_CVD) begin
            for (int i = 0; i < 9; i++) begin
                if (needs_six(wide_work_register[4 * i +: 4]))
                    parallel_input_b[4 * i +: 4] = 4'h6;
            end
        end
        parallel_sum_latch = parallel_input_a + parallel_input_b + {63'h0, serial_sum_latch[7]};
        asc_sum = next_instr_counter_in + (~addr_in + 24'h1);
        asc_hit = ((asc_sum >> `ASC_SHIFT) == 24'h0);
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            state <= S_IDLE;
            op <= dcs_pkg::OP_NONE;
            adder_byte_counter <= 3'h0;
            serial_byte_counter <= 3'h0;
            serial_sum_latch <= 8'h0;
            source <= 64'h0;
            wide_work_register <= 68'h0;
            shift_pair_register <= 64'h0;
            outbound_doubleword_register <= 64'h0;
            marks <= 8'h0;
            sign_flag <= 1'b0;
            issue <= 1'b0;
            end_op_out <= 1'b0;
            spec_int_out <= 1'b0;
            wait_count <= 3'h0;
            result_out <= 64'h0;
        end else begin
            issue <= 1'b0;
            end_op_out <= 1'b0;
            spec_int_out <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start_in) begin
                        op <= op_in;
                        adder_byte_counter <= 3'h0;
                        wide_work_register <= 68'h0;
                        shift_pair_register <= 64'h0;
                        marks <= 8'h0;
                        if (op_in == dcs_pkg::OP_CVD) begin
                            sign_flag <= operand_in[31];
                            source <= operand_in[31] ? {32'h0, -operand_in[31:0]} : {32'h0, operand_in[31:0]};
                            serial_byte_counter <= 3'h0;
                            serial_sum_latch <= operand_in[31] ? -operand_in[31:24] - {7'h0, |operand_in[23:0]}
                                : operand_in[31:24];
                            state <= S_CONV;
                        end else if (op_in == dcs_pkg::OP_ST) begin
                            if (addr_in[1:0] != 2'h0) begin
                                spec_int_out <= 1'b1;
                                end_op_out <= 1'b1;
                            end else begin
                                // Sum bit 61 is address bit 21 here
                                outbound_doubleword_register <= {operand_in[31:0], operand_in[31:0]};
                                marks <= addr_in[2] ? 8'h0F : 8'hF0;
                                issue <= 1'b1;
                                wait_count <= 3'h3;
                                state <= S_WAIT;
                            end
                        end else if (op_in == dcs_pkg::OP_STH) begin
                            if (addr_in[0]) begin
                                spec_int_out <= 1'b1;
                                end_op_out <= 1'b1;
                            end else begin
                                serial_byte_counter <= addr_in[2:0];
                                source <= {48'h0, operand_in[15:0]};
                                adder_byte_counter <= `ABC_ALL_ONES - 3'h1;
                                state <= S_HIGH;
                            end
                        end else begin
                            end_op_out <= 1'b1;
                        end
                    end
                end
                S_CONV, S_TERM: begin
                    wide_work_register <= {4'h0, parallel_sum_latch};
                    shift_pair_register <= parallel_sum_latch;
                    serial_sum_latch <= {serial_sum_latch[6:0], 1'b0};
                    adder_byte_counter <= adder_byte_counter + 3'h1;
                    if (adder_byte_counter == 3'h7) begin
                        adder_byte_counter <= 3'h0;
                        serial_byte_counter <= serial_byte_counter + 3'h1;
                        if (serial_byte_counter == `CONV_LAST_BYTE) begin
                            state <= S_SIGN;
                        end else begin
                            serial_sum_latch <= source[8 * (3'h2 - serial_byte_counter) +: 8];
                        end
                    end else if (adder_byte_counter >= 3'h4 && serial_byte_counter == `CONV_LAST_BYTE)
                        state <= S_TERM;
                end
                S_SIGN: begin
                    wide_work_register[67:64] <= sign_flag ? (minus_alt_in ? `SIGN_MINUS_ALT : `SIGN_MINUS)
                        : `SIGN_PLUS;
                    outbound_doubleword_register <= {wide_work_register[59:0], sign_flag ?
                        (minus_alt_in ? `SIGN_MINUS_ALT : `SIGN_MINUS) : `SIGN_PLUS};
                    result_out <= {wide_work_register[59:0], sign_flag ? (minus_alt_in ? `SIGN_MINUS_ALT
                        : `SIGN_MINUS) : `SIGN_PLUS};
                    marks <= 8'hFF;
                    issue <= 1'b1;
                    wait_count <= 3'h3;
                    state <= S_WAIT;
                end
                S_HIGH: begin
                    outbound_doubleword_register <= byte_place(source[15:8], serial_byte_counter);
                    marks <= mark_of(serial_byte_counter);
                    issue <= 1'b1;
                    adder_byte_counter <= adder_byte_counter + 3'h1;
                    serial_byte_counter <= serial_byte_counter + 3'h1;
                    state <= S_LOW;
                end
                S_LOW: begin
                    outbound_doubleword_register <= byte_place(source[7:0], serial_byte_counter);
                    marks <= mark_of(serial_byte_counter);
                    wait_count <= 3'h2;
                    state <= S_WAIT;
                end
                S_WAIT: begin
                    wait_count <= wait_count - 3'h1;
                    if (wait_count == 3'h1) begin
                        end_op_out <= 1'b1;
                        op <= dcs_pkg::OP_NONE;
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Refetch and protection
    // ----------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            refetch_trigger <= 1'b0;
        end else if (issue && asc_hit) begin
            refetch_trigger <= 1'b1;
        end else if (ifetch_in) begin
            refetch_trigger <= 1'b0;
        end
    end
    assign refetch_out = refetch_trigger && ifetch_in;

    // Interrupt waits one full instruction after the failed store
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            late_prot <= 1'b0;
            prot_armed <= 1'b0;
            prot_int_out <= 1'b0;
        end else begin
            prot_int_out <= 1'b0;
            if (prot_check_in && state == S_WAIT) begin
                late_prot <= 1'b1;
            end else if (late_prot && end_op_out) begin
                // Own end-op first; the next one raises it
                late_prot <= 1'b0;
                prot_armed <= 1'b1;
            end else if (prot_armed && end_op_out) begin
                prot_armed <= 1'b0;
                prot_int_out <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Storage request staging
    // ----------------------------------------
    always_comb begin
        req.data = outbound_doubleword_register;
        req.marks = marks;
        if (!issue && state != S_WAIT) begin
            req = '0;
        end
    end

    store_delay u_store_delay (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .issue_in(issue),
        .cancel_in(prot_check_in),
        .req_in(req),
        .write_out(mem_write_out),
        .req_out(req_done)
    );
    assign mem_data_out = req_done.data;
    assign mem_marks_out = req_done.marks;
    assign busy_out = (state != S_IDLE);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_sign_plus;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (state == S_SIGN && !sign_flag) |=> (outbound_doubleword_register[3:0] == 4'hC);
    endproperty
    a_sign_plus: assert property (p_sign_plus) else $error("plus sign wrong");
    property p_all_marks;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (state == S_SIGN) |=> (marks == 8'hFF) && issue;
    endproperty
    a_all_marks: assert property (p_all_marks) else $error("marks not all set");
    property p_spec;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (state == S_IDLE && start_in && op_in == dcs_pkg::OP_STH && addr_in[0]) |=> spec_int_out && !issue;
    endproperty
    a_spec: assert property (p_spec) else $error("spec check missed");
    property p_excess_only_cvd;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (op != dcs_pkg::OP_CVD) |-> (parallel_input_b == 64'h0);
    endproperty
    a_excess_only_cvd: assert property (p_excess_only_cvd) else $error("excess gate outside convert");
    property p_mem_delay;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (issue && !prot_check_in) |-> ##3 mem_write_out || $past(prot_check_in);
    endproperty
    a_mem_delay: assert property (p_mem_delay) else $error("write not three later");
    property p_abc_six;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (state == S_IDLE && start_in && op_in == dcs_pkg::OP_STH && !addr_in[0]) |=> adder_byte_counter == 3'h6;
    endproperty
    a_abc_six: assert property (p_abc_six) else $error("adder counter not six");
    property p_st_marks;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (state == S_IDLE && start_in && op_in == dcs_pkg::OP_ST && addr_in[1:0] == 2'h0)
        |=> marks == (addr_in[2] ? 8'h0F : 8'hF0);
    endproperty
    a_st_marks: assert property (p_st_marks) else $error("fullword marks wrong");
    property p_refetch;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (issue && asc_hit) |=> refetch_trigger;
    endproperty
    a_refetch: assert property (p_refetch) else $error("refetch not set");
    property p_fix;
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (op == dcs_pkg::OP_CVD && wide_work_register[3:0] == 4'h5) |-> parallel_input_b[3:0] == 4'h6;
    endproperty
    a_fix: assert property (p_fix) else $error("add six missed");
    c_cvd: cover property (@(posedge sys_clk_in) state == S_SIGN);
    c_sth: cover property (@(posedge sys_clk_in) state == S_LOW);
    c_prot: cover property (@(posedge sys_clk_in) prot_int_out);
endmodule : dcs_exec
`default_nettype wire

// [verilog/dcs_defs.svh]
/*
 Constants for the decimal-convert and store execution datapath.
 Assumes inclusion by bare name from design files.
*/
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH
`define SIGN_PLUS 4'hC
`define SIGN_MINUS 4'hD
`define SIGN_MINUS_ALT 4'hB
`define CONV_LAST_BYTE 3'h3
`define CONV_BRANCH_BITS 3'h3
`define ABC_ALL_ONES 3'h7
`define ASC_SHIFT 4
`define MEM_REQ_CYCLES 2'h3
`define FIX_LO 28
`endif

// [verilog/dcs_pkg.sv]
/*
 Types shared by the datapath and its storage-request staging.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dcs_pkg;
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_CVD = 4'h1,
        OP_ST = 4'h2,
        OP_STH = 4'h3
    } op_e;
    typedef struct packed {
        logic [63:0] data;
        logic [7:0] marks;
    } store_req_s;
endpackage : dcs_pkg

// [verilog/store_delay.sv]
/*
 Holds a doubleword store request for the three-cycle storage delay.
 Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcs_defs.svh"
module store_delay (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic issue_in,
    input wire logic cancel_in,
    input wire dcs_pkg::store_req_s req_in,
    output logic write_out,
    output dcs_pkg::store_req_s req_out
);
    logic [1:0] count;
    logic busy;
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            count <= 2'h0;
            busy <= 1'b0;
            write_out <= 1'b0;
            req_out <= '0;
        end else begin
            write_out <= 1'b0;
            if (issue_in) begin
                busy <= 1'b1;
                count <= `MEM_REQ_CYCLES - 2'h1;
                req_out <= req_in;
            end else if (busy) begin
                // Later bytes may still arrive before the write
                req_out.data <= req_out.data | req_in.data;
                req_out.marks <= req_out.marks | req_in.marks;
                if (count == 2'h1) begin
                    busy <= 1'b0;
                    write_out <= !cancel_in;
                end
                count <= count - 2'h1;
            end
        end
    end
endmodule : store_delay
`default_nettype wire

// [verification/storage_model.sv]
/*
 Main storage model: doubleword writes gated per byte by the marks.
 Assumes one clock, sync active-low reset, address held by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module storage_model (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic mem_write_in,
    input wire logic [63:0] mem_data_in,
    input wire logic [7:0] mem_marks_in,
    input wire logic [23:0] addr_in,
    input wire logic protect_in,
    input wire logic [23:0] peek_addr_in,
    output logic prot_check_out,
    output logic [63:0] peek_data_out
);
    // ----------------------------------------
    // Storage array
    // ----------------------------------------
    logic [63:0] mem [16];
    // Key mismatch reported as a level for the whole wait
    assign prot_check_out = protect_in;
    assign peek_data_out = mem[peek_addr_in[6:3]];
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < 16; i++) begin
                mem[i] <= 64'h0;
            end
        end else if (mem_write_in && !protect_in) begin
            for (int b = 0; b < 8; b++) begin
                if (mem_marks_in[b]) begin
                    mem[addr_in[6:3]][8*b +: 8] <= mem_data_in[8*b +: 8];
                end
            end
        end
    end
endmodule : storage_model
`default_nettype wire

// [verification/tb.sv]
/*
 Self-checking bench: store, halfword store, convert, protection.
 Assumes the package, design files and storage model compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic sys_clk_in;
    logic rstn_in = 1'b0;
    logic start_in = 1'b0;
    dcs_pkg::op_e op_in = dcs_pkg::OP_NONE;
    logic [63:0] operand_in = 64'h0;
    logic [23:0] addr_in = 24'h0;
    logic [23:0] pc = 24'h0;
    logic alt = 1'b0;
    logic protect = 1'b0;
    logic ifetch_in = 1'b0;
    logic [23:0] peek_addr = 24'h0;
    logic prot_check, busy, end_op, spec_int, prot_int, refetch, mem_write;
    logic [63:0] mem_data;
    logic [7:0] mem_marks;
    logic [63:0] peek;
    logic [63:0] result;
    logic [63:0] halves;
    logic [31:0] v;
    logic [31:0] cv [6] = '{32'h0, 32'h92, 32'hFFFFFF6E, 32'h7FFFFFFF, 32'h80000000, 32'hFFFFFFFF};
    logic [73:0] exp_q [$];
    int fails = 0;
    int n_checks = 0;
    int n_prot = 0;

    dcs_exec dcs_exec_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .start_in(start_in),
        .op_in(op_in), .operand_in(operand_in), .addr_in(addr_in), .next_instr_counter_in(pc),
        .minus_alt_in(alt), .prot_check_in(prot_check), .ifetch_in(ifetch_in), .busy_out(busy),
        .end_op_out(end_op), .spec_int_out(spec_int), .prot_int_out(prot_int),
        .refetch_out(refetch), .mem_write_out(mem_write), .mem_data_out(mem_data),
        .mem_marks_out(mem_marks), .result_out(result));
    storage_model storage_model_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
        .mem_write_in(mem_write), .mem_data_in(mem_data), .mem_marks_in(mem_marks),
        .addr_in(addr_in), .protect_in(protect), .peek_addr_in(peek_addr),
        .prot_check_out(prot_check), .peek_data_out(peek));

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [73:0] seen, input logic [73:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic take(input logic [1:0] kind, input logic [71:0] seen);
        logic [73:0] e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 74'h0;
        check({kind, seen}, e);
    endtask : take

    function automatic logic [63:0] mask(input logic [7:0] m);
        logic [63:0] r;
        for (int i = 0; i < 8; i++) begin
            r[8*i +: 8] = {8{m[i]}};
        end
        return r;
    endfunction : mask

    function automatic logic [63:0] to_dec(input logic [31:0] mag);
        logic [63:0] r;
        longint m;
        r = 64'h0;
        m = mag;
        for (int i = 0; i < 15; i++) begin
            r[4*i +: 4] = 4'(m % 10);
            m = m / 10;
        end
        return r;
    endfunction : to_dec

    // Upper operand half is random junk: only the low part may reach storage
    task automatic run_op(input dcs_pkg::op_e op, input logic [31:0] opd, input logic [23:0] a,
                          input logic [23:0] ic, input logic mal, input logic prot);
        logic [23:0] d;
        int k;
        d = ic - a;
        exp_q.push_back({2'h3, 71'h0, d[23:4] == 20'h0});
        @(posedge sys_clk_in);
        start_in <= 1'b1;
        op_in <= op;
        operand_in <= {$urandom(), opd};
        addr_in <= a;
        pc <= ic;
        alt <= mal;
        protect <= prot;
        @(posedge sys_clk_in);
        start_in <= 1'b0;
        for (k = 0; k < 200; k++) begin
            @(negedge sys_clk_in);
            if (end_op === 1'b1) break;
        end
        if (k == 200) begin
            fails++;
            stop_test();
        end
        check({73'h0, busy}, 74'h0);
        @(posedge sys_clk_in);
        protect <= 1'b0;
        ifetch_in <= 1'b1;
        @(posedge sys_clk_in);
        ifetch_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
    endtask : run_op

    task automatic st_op(input logic [31:0] opd, input logic [23:0] a, input logic [23:0] ic,
                         input logic prot);
        if (!prot) begin
            exp_q.push_back((a[1:0] != 2'h0) ? {2'h2, 72'h0} :
                a[2] ? {2'h1, 8'h0F, 32'h0, opd} : {2'h1, 8'hF0, opd, 32'h0});
        end
        run_op(dcs_pkg::OP_ST, opd, a, ic, 1'b0, prot);
    endtask : st_op

    task automatic sth_op(input logic [15:0] h, input logic [23:0] a);
        logic [63:0] dd;
        dd = {48'h0, h} << (48 - 8 * int'(a[2:0]));
        exp_q.push_back(a[0] ? {2'h2, 72'h0} : {2'h1, 8'hC0 >> a[2:0], dd});
        run_op(dcs_pkg::OP_STH, {16'($urandom()), h}, a, 24'h100000, 1'b0, 1'b0);
    endtask : sth_op

    task automatic cvd_op(input logic [31:0] b, input logic mal);
        logic [31:0] mag;
        logic [63:0] dv;
        logic [3:0] sg;
        mag = b[31] ? -b : b;
        dv = to_dec(mag);
        sg = b[31] ? (mal ? 4'hB : 4'hD) : 4'hC;
        // Full digit result checks the loop, doubling and excess-6 steps
        exp_q.push_back({2'h1, 8'hFF, dv[59:0], sg});
        run_op(dcs_pkg::OP_CVD, b, 24'h000080, 24'h100000, mal, 1'b0);
        check({10'h0, result}, {10'h0, dv[59:0], sg});
    endtask : cvd_op

    // ----------------------------------------
    // Output watcher
    // ----------------------------------------
    initial begin
        forever begin
            @(negedge sys_clk_in);
            if (prot_int === 1'b1) n_prot++;
            if (mem_write === 1'b1) take(2'h1, {mem_marks, mem_data & mask(mem_marks)});
            if (spec_int === 1'b1) take(2'h2, 72'h0);
            if (ifetch_in === 1'b1) take(2'h3, {71'h0, refetch});
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h79CD));
        repeat (10) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        st_op(32'h12345678, 24'h000104, 24'h000104, 1'b0);
        st_op(32'h9ABCDEF0, 24'h000100, 24'h100000, 1'b0);
        st_op(32'h0BADF00D, 24'h000102, 24'h100000, 1'b0);
        halves = 64'h0;
        for (int n = 0; n < 8; n += 2) begin
            v = $urandom();
            halves[48 - 8*n +: 16] = v[15:0];
            sth_op(v[15:0], 24'h000040 + 24'(n));
        end
        sth_op(16'h1234, 24'h000045);
        @(posedge sys_clk_in);
        peek_addr <= 24'h000040;
        @(negedge sys_clk_in);
        check({10'h0, peek}, {10'h0, halves});
        st_op(32'h55AA55AA, 24'h000108, 24'h100000, 1'b1);
        check(74'(n_prot), 74'h0);
        st_op(32'h0F0F0F0F, 24'h00010C, 24'h100000, 1'b0);
        check(74'(n_prot), 74'h1);
        foreach (cv[i]) begin
            cvd_op(cv[i], 1'(i));
        end
        repeat (4) begin
            cvd_op($urandom(), 1'($urandom()));
        end
        repeat (5) @(posedge sys_clk_in);
        check(74'(exp_q.size()), 74'h0);
        stop_test();
    end
endmodule : tb
`default_nettype wire
